// ---- sim/sgp_gpio_port_chk.sv ----
// assertions on the gpio port: read answers, key sequence, drive outputs
// assumes it is bound into sgp_gpio_port
`timescale 1ns/1ps
`default_nettype none
module sgp_gpio_port_chk
	import sgp_pkg::*;
#(
	parameter int LINES = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire sgp_io_req_t io_req,
	input wire logic [7:0] io_rdata,
	input wire logic io_rvalid,
	input wire logic [LINES-1:0] gpio_in,
	input wire logic [LINES-1:0] gpio_out,
	input wire logic [LINES-1:0] gpio_oe,
	input wire logic cfg_open
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence key_s;
		io_req.wr && io_req.addr == 16'h002E && io_req.wdata == 8'h87;
	endsequence
	rd_answer_a: assert property (io_req.rd |=> io_rvalid)
		else $error("read not answered");
	rd_only_a: assert property (io_rvalid |-> $past(io_req.rd))
		else $error("answer without read");
	key_open_a: assert property (key_s ##1 !io_req.wr ##1 key_s |=> cfg_open)
		else $error("key did not unlock");
	open_cause_a: assert property ($rose(cfg_open) |-> $past(io_req.wdata) == 8'h87)
		else $error("unlocked without key");
	lock_key_a: assert property (io_req.wr && io_req.addr == 16'h002E && io_req.wdata == 8'hAA |=> !cfg_open)
		else $error("lock byte ignored");
	locked_rd_a: assert property (!cfg_open && io_req.rd |=> io_rdata == 8'hFF)
		else $error("locked read not idle");
	oe_cause_a: assert property ($changed(gpio_oe) |-> $past(io_req.wr && io_req.addr == 16'h002F && cfg_open, 2))
		else $error("enable moved without write");
	out_cause_a: assert property ($changed(gpio_out) |-> $past(io_req.wr && io_req.addr == 16'h002F && cfg_open, 2))
		else $error("drive moved without write");
endmodule
bind sgp_gpio_port sgp_gpio_port_chk #(.LINES(LINES)) chk_inst(.ref_clk(ref_clk), .rst(rst), .io_req(io_req),
	.io_rdata(io_rdata), .io_rvalid(io_rvalid), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
	.cfg_open(cfg_open));
`default_nettype wire

// ---- sim/sgp_gpio_port_test.sv ----
// self-checking bench for the gpio configuration port
// assumes sgp_host drives requests; driven lines loop back onto the pins
`timescale 1ns/1ps
`default_nettype none
module sgp_gpio_port_test
	import sgp_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] ext = 8'h30;
	logic [7:0] rdata, gout, oe, d;
	logic rv, open;
	sgp_io_req_t req;
	int bad_count = 0;
	int checks_done = 0;
	wire logic [7:0] pins = (gout & oe) | (ext & ~oe);
	always #20 ref_clk = ~ref_clk;
	sgp_host host_inst(.ref_clk(ref_clk), .io_rdata(rdata), .io_req(req));
	sgp_gpio_port sgp_gpio_port_inst(.ref_clk(ref_clk), .rst(rst), .io_req(req), .io_rdata(rdata),
		.io_rvalid(rv), .gpio_in(pins), .gpio_out(gout), .gpio_oe(oe), .cfg_open(open));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(input string n, input logic [7:0] i, input logic [7:0] e);
		host_inst.get(i, d);
		chk(n, e, d);
		chk("rvalid", 8'h01, {7'h00, rv});
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		rchk("locked", 8'hE0, 8'hFF);
		host_inst.io_wr(16'h002E, 8'h87);
		host_inst.set(8'h07, 8'h07);
		chk("broken key", 8'h00, {7'h00, open});
		host_inst.unlock();
		chk("open", 8'h01, {7'h00, open});
		host_inst.set(8'h07, 8'h07);
		host_inst.set(8'hE0, 8'hF0);
		host_inst.set(8'hE2, 8'h0F);
		host_inst.set(8'hE1, 8'hA5);
		rchk("dir", 8'hE0, 8'hF0);
		chk("oe off", 8'h00, oe);
		host_inst.set(8'h07, 8'h09);
		rchk("bank", 8'hE0, 8'h00);
		host_inst.set(8'h30, 8'h81);
		rchk("fen", 8'h30, 8'h81);
		chk("oe", 8'h0F, oe);
		chk("out", 8'h0A, gout);
		host_inst.set(8'h07, 8'h07);
		rchk("val", 8'hE1, 8'h35);
		host_inst.io_rd(16'h002E, d);
		chk("index", 8'hE1, d);
		host_inst.set(8'hE1, 8'hFF);
		host_inst.set(8'hE2, 8'hF0);
		@(posedge ref_clk) ext <= 8'h90;
		rchk("val inv", 8'hE1, 8'h6F);
		chk("out inv", 8'hFF, gout);
		host_inst.io_wr(16'h002E, 8'hAA);
		chk("lock", 8'h00, {7'h00, open});
		rchk("relocked", 8'hE1, 8'hFF);
		// a mid-run reset must bring the output enables, direction and polarity back, not only the key state
		@(posedge ref_clk) rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		chk("reset oe", 8'h00, oe);
		host_inst.unlock();
		host_inst.set(8'h07, 8'h07);
		rchk("reset dir", 8'hE0, 8'hFF);
		rchk("reset pol", 8'hE2, 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- sim/sgp_host.sv ----
// host model issuing byte i/o cycles on the index/data port pair
// assumes ref_clk from the bench; requests change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module sgp_host
	import sgp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [7:0] io_rdata,
	output var sgp_io_req_t io_req
);
	initial io_req = '0;
	// one idle cycle between cycles keeps each strobe a clean single pulse
	task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk) io_req <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk) io_req <= '0;
		#1;
	endtask
	task automatic set(input logic [7:0] i, input logic [7:0] d);
		io_wr(16'h002E, i);
		io_wr(16'h002F, d);
	endtask
	// read data stand for one cycle after the edge that takes the strobe
	task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge ref_clk) io_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk) io_req <= '0;
		#1 d = io_rdata;
	endtask
	task automatic get(input logic [7:0] i, output logic [7:0] d);
		io_wr(16'h002E, i);
		io_rd(16'h002F, d);
	endtask
	task automatic unlock;
		io_wr(16'h002E, 8'h87);
		io_wr(16'h002E, 8'h87);
	endtask
endmodule
`default_nettype wire

// ---- src/sgp_gpio_port.sv ----
// gpio port behind an index/data configuration port pair with key-protected access
// assumes the host presents one-cycle rd/wr strobes with a 16-bit i/o address on ref_clk;
// read data is registered and valid the cycle after the rd strobe
`timescale 1ns/1ps
`default_nettype none
`include "sgp_params.svh"
module sgp_gpio_port
	import sgp_pkg::*;
#(
	parameter int LINES = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire sgp_io_req_t io_req,
	output logic [7:0] io_rdata,
	output logic io_rvalid,
	input wire logic [LINES-1:0] gpio_in,
	output logic [LINES-1:0] gpio_out,
	output logic [LINES-1:0] gpio_oe,
	output logic cfg_open
);
	sgp_cfg_state_t state_ff, nxt_state;
	logic [7:0] index_ff, nxt_index;
	logic [7:0] ldn_ff, nxt_ldn;
	logic [7:0] fen_ff, nxt_fen;
	logic [LINES-1:0] dir_ff, nxt_dir;
	logic [LINES-1:0] val_ff, nxt_val;
	logic [LINES-1:0] pol_ff, nxt_pol;
	logic [7:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;
	logic [LINES-1:0] out_ff, nxt_out;
	logic [LINES-1:0] oe_ff, nxt_oe;
	logic [LINES-1:0] pin_sync;
	logic [LINES-1:0] pin_view;
	logic [LINES-1:0] line_view;
	logic idx_wr, idx_rd, dat_wr, dat_rd, open;
	logic sel_fen, sel_dir, sel_val, sel_pol;
	logic open_ff, nxt_open;

	sgp_sync #(
		.WIDTH(LINES)
	) sgp_sync_inst (
		.ref_clk(ref_clk),
		.rst(rst),
		.din(gpio_in),
		.dout(pin_sync)
	);

	function automatic logic [7:0] widen(input logic [LINES-1:0] v);
		logic [7:0] r;
		r = '0;
		r[LINES-1:0] = v;
		return r;
	endfunction

	function automatic logic bank_hit(input logic [7:0] ldn, input logic [7:0] want);
		return ldn == want;
	endfunction

	// one decode shared by the write and the read path so the two cannot disagree
	function automatic logic reg_hit(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] want_ldn,
		input logic [7:0] want_idx);
		return bank_hit(ldn, want_ldn) && (idx == want_idx);
	endfunction

	function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
		return addr == port;
	endfunction

	// takes fresh where keep is clear and old where keep is set
	function automatic logic [LINES-1:0] merge(input logic [LINES-1:0] fresh, input logic [LINES-1:0] old,
		input logic [LINES-1:0] keep);
		return (fresh & ~keep) | (old & keep);
	endfunction

	// while locked only the index port listens, and only to the key
	assign open = (state_ff == SGP_OPEN);
	assign idx_wr = io_req.wr && port_hit(io_req.addr, `SGP_IDX_PORT);
	assign idx_rd = io_req.rd && port_hit(io_req.addr, `SGP_IDX_PORT) && open;
	assign dat_wr = io_req.wr && port_hit(io_req.addr, `SGP_DAT_PORT) && open;
	assign dat_rd = io_req.rd && port_hit(io_req.addr, `SGP_DAT_PORT) && open;

	// the device-select index is decoded apart because it answers in every bank
	assign sel_fen = reg_hit(ldn_ff, index_ff, `SGP_LDN_FEN, `SGP_IDX_FEN);
	assign sel_dir = reg_hit(ldn_ff, index_ff, `SGP_LDN_GPIO, `SGP_IDX_DIR);
	assign sel_val = reg_hit(ldn_ff, index_ff, `SGP_LDN_GPIO, `SGP_IDX_VAL);
	assign sel_pol = reg_hit(ldn_ff, index_ff, `SGP_LDN_GPIO, `SGP_IDX_POL);

	// input lines show the pin through the polarity mask
	assign pin_view = pin_sync ^ pol_ff;
	// output lines read back the value register, input lines the pin
	assign line_view = merge(val_ff, pin_view, dir_ff);

	// key sequence: any other byte between the two unlock writes restarts it
	always_comb
	begin
		nxt_state = state_ff;
		if (idx_wr)
		begin
			unique case (state_ff)
				SGP_LOCKED: nxt_state = (io_req.wdata == `SGP_KEY_UNLOCK) ? SGP_KEY1 : SGP_LOCKED;
				SGP_KEY1: nxt_state = (io_req.wdata == `SGP_KEY_UNLOCK) ? SGP_OPEN : SGP_LOCKED;
				SGP_OPEN: nxt_state = (io_req.wdata == `SGP_KEY_LOCK) ? SGP_LOCKED : SGP_OPEN;
				default: nxt_state = SGP_LOCKED;
			endcase
		end
		// cfg_open is a registered copy so the port comes straight from a flop
		nxt_open = (nxt_state == SGP_OPEN);
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= SGP_LOCKED;
			open_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			open_ff <= nxt_open;
		end
	end

	always_comb
	begin
		nxt_index = index_ff;
		// the lock byte is a command, never a register number
		if (idx_wr && open && io_req.wdata != `SGP_KEY_LOCK)
			nxt_index = io_req.wdata;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			index_ff <= `SGP_RST_IDX;
		end
		else
		begin
			index_ff <= nxt_index;
		end
	end

	always_comb
	begin
		nxt_ldn = ldn_ff;
		// the select index is reached from every bank
		if (dat_wr && index_ff == `SGP_IDX_LDSEL)
			nxt_ldn = io_req.wdata;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ldn_ff <= `SGP_RST_LDN;
		end
		else
		begin
			ldn_ff <= nxt_ldn;
		end
	end

	always_comb
	begin
		nxt_fen = fen_ff;
		// all bits are stored so a read-modify-write keeps the others
		if (dat_wr && sel_fen)
			nxt_fen = io_req.wdata;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			fen_ff <= `SGP_RST_FEN;
		end
		else
		begin
			fen_ff <= nxt_fen;
		end
	end

	always_comb
	begin
		nxt_dir = dir_ff;
		if (dat_wr && sel_dir)
			nxt_dir = io_req.wdata[LINES-1:0];
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			dir_ff <= LINES'(`SGP_RST_DIR);
		end
		else
		begin
			dir_ff <= nxt_dir;
		end
	end

	always_comb
	begin
		nxt_val = val_ff;
		// bits of input lines ignore the write
		if (dat_wr && sel_val)
			nxt_val = merge(io_req.wdata[LINES-1:0], val_ff, dir_ff);
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			val_ff <= LINES'(`SGP_RST_VAL);
		end
		else
		begin
			val_ff <= nxt_val;
		end
	end

	always_comb
	begin
		nxt_pol = pol_ff;
		if (dat_wr && sel_pol)
			nxt_pol = io_req.wdata[LINES-1:0];
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pol_ff <= LINES'(`SGP_RST_POL);
		end
		else
		begin
			pol_ff <= nxt_pol;
		end
	end

	always_comb
	begin
		nxt_rvalid = io_req.rd;
		nxt_rdata = `SGP_RD_IDLE;
		if (dat_rd)
		begin
			// unknown indices and banks read as zero while open
			nxt_rdata = `SGP_RD_NONE;
			if (index_ff == `SGP_IDX_LDSEL)
				nxt_rdata = ldn_ff;
			else if (sel_fen)
				nxt_rdata = fen_ff;
			else if (sel_dir)
				nxt_rdata = widen(dir_ff);
			else if (sel_pol)
				nxt_rdata = widen(pol_ff);
			else if (sel_val)
				nxt_rdata = widen(line_view);
		end
		else if (idx_rd)
			nxt_rdata = index_ff;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_ff <= `SGP_RD_IDLE;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	always_comb
	begin
		// pins stay released until the function is enabled
		nxt_oe = fen_ff[`SGP_FEN_BIT] ? ~dir_ff : '0;
		nxt_out = val_ff ^ pol_ff;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			out_ff <= '0;
			oe_ff <= '0;
		end
		else
		begin
			out_ff <= nxt_out;
			oe_ff <= nxt_oe;
		end
	end

	assign io_rdata = rdata_ff;
	assign io_rvalid = rvalid_ff;
	assign gpio_out = out_ff;
	assign gpio_oe = oe_ff;
	assign cfg_open = open_ff;
endmodule
`default_nettype wire

// ---- src/sgp_params.svh ----
// constants for the configuration-port gpio block: port addresses, key bytes, indices, resets
// assumes the host issues single-byte i/o cycles already decoded to address and strobes
//
// Contract
// - double unlock byte write enters configuration mode
// - lock byte write leaves configuration mode
// - index port selects, data port accesses register
// - device-select index switches banks; gpio in seven
// - bank nine index 30 bit 7 enables gpio
// - direction bit one input, zero output
// - output value bits rw; input bits read pins
// - polarity bit inverts input and output
`ifndef SGP_PARAMS_SVH
`define SGP_PARAMS_SVH
`define SGP_IDX_PORT 16'h002E
`define SGP_DAT_PORT 16'h002F
`define SGP_KEY_UNLOCK 8'h87
`define SGP_KEY_LOCK 8'hAA
`define SGP_IDX_LDSEL 8'h07
`define SGP_IDX_FEN 8'h30
`define SGP_IDX_DIR 8'hE0
`define SGP_IDX_VAL 8'hE1
`define SGP_IDX_POL 8'hE2
`define SGP_LDN_GPIO 8'h07
`define SGP_LDN_FEN 8'h09
`define SGP_FEN_BIT 7
`define SGP_RST_DIR 8'hFF
`define SGP_RST_VAL 8'h00
`define SGP_RST_POL 8'h00
`define SGP_RST_FEN 8'h00
`define SGP_RST_IDX 8'h00
`define SGP_RST_LDN 8'h00
`define SGP_RD_NONE 8'h00
`define SGP_RD_IDLE 8'hFF
`endif

// ---- src/sgp_pkg.sv ----
// types for the configuration-port gpio block
// assumes sgp_params.svh is on the include path
package sgp_pkg;
	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sgp_io_req_t;
	typedef enum logic [1:0]
	{
		SGP_LOCKED = 2'b00,
		SGP_KEY1 = 2'b01,
		SGP_OPEN = 2'b11
	} sgp_cfg_state_t;
endpackage

// ---- src/sgp_sync.sv ----
// two flip-flop synchroniser for the gpio pin levels
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module sgp_sync #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end
	assign dout = sync_ff;
endmodule
`default_nettype wire
